/* design/rcrm_bank.sv */
// module: control register bank with global and per channel registers
`timescale 1ns/1ps
`default_nettype none
module rcrm_bank (
   input wire logic sys_clk,
   input wire logic rst_b,
   input wire rcrm_pkg::rcrm_req_t req,
   input wire rcrm_pkg::rcrm_io_t io_status,
   output logic [31:0] rd_data,
   output logic traffic_gen_enable,
   output logic [15:0] user_output_control,
   output rcrm_pkg::rcrm_chan_t [rcrm_pkg::NUM_CHAN-1:0] chan
);
   import rcrm_pkg::*;

   typedef struct packed {
      logic [31:0] scratch;
      logic traffic;
      logic [15:0] uout_ctrl;
      logic [31:0] rd;
      rcrm_chan_t [NUM_CHAN-1:0] ch;
   } rcrm_state_t;

   rcrm_state_t state;
   rcrm_state_t next_state;

   // ----------------------------------------
   // address decoding
   // ----------------------------------------
   function automatic logic is_chan(input logic [15:0] a, input logic [3:0] sub, input int unsigned c);
      is_chan = (a[15:12] == CHAN_PREFIX) && (a[11:8] == c[3:0]) && (a[7:4] == CHAN_MID) && (a[3:0] == sub); // RULE10
   endfunction

   // applies a two-bit on/off code only when it differs from prev; every caller here passes
   // prev as 00, so each write of 01 or 10 acts again even if it repeats the stored code
   function automatic logic apply_code(input logic cur, input logic [1:0] code, input logic [1:0] prev);
      apply_code = cur;
      if (code != prev) begin // RULE20
         if (code == CODE_ON) begin // RULE4
            apply_code = 1'b1;
         end else if (code == CODE_OFF) begin
            apply_code = 1'b0;
         end
      end
   endfunction

   // ----------------------------------------
   // next state
   // ----------------------------------------
   always_comb begin
      logic [1:0] code;
      code = 2'h0;
      next_state = state;
      for (int unsigned c = 0; c < NUM_CHAN; c++) begin
         next_state.ch[c].event_pulse = 1'b0;
         next_state.ch[c].lut_we = 1'b0;
      end
      if (req.wr_en) begin // RULE19
         case (req.addr)
            OFS_SCRATCH: begin
               next_state.scratch = req.wr_data; // RULE1
            end
            OFS_TRAFFIC: begin
               next_state.traffic = req.wr_data[0]; // RULE2
            end
            OFS_UOUT_CTRL: begin
               next_state.uout_ctrl = req.wr_data[15:0]; // RULE3
            end
            default: begin
            end
         endcase
         for (int unsigned c = 0; c < NUM_CHAN; c++) begin
            code = req.wr_data[BYP_LSB+:2];
            if (is_chan(req.addr, SUB_LINE, c)) begin
               next_state.ch[c].line_bypass = apply_code(state.ch[c].line_bypass, req.wr_data[1:0], 2'h0); // RULE11
               next_state.ch[c].line_code = req.wr_data[1:0];
            end
            if (is_chan(req.addr, SUB_EVENT, c)) begin
               next_state.ch[c].event_arg = req.wr_data; // RULE12
               next_state.ch[c].event_pulse = 1'b1; // RULE12
            end
            if (is_chan(req.addr, SUB_LUT, c)) begin
               next_state.ch[c].lut_bypass = apply_code(state.ch[c].lut_bypass, code, 2'h0); // RULE15
               next_state.ch[c].lut_code = code;
               if (req.wr_data[LUT_START_BIT]) begin // RULE13
                  next_state.ch[c].lut_loading = 1'b1;
                  next_state.ch[c].lut_done = 1'b0;
                  next_state.ch[c].lut_index = 8'h00;
               end
            end
            if (is_chan(req.addr, SUB_COEF, c)) begin
               next_state.ch[c].lut_we = 1'b1; // RULE16
               next_state.ch[c].lut_addr = state.ch[c].lut_index;
               next_state.ch[c].lut_data = req.wr_data[7:0];
               next_state.ch[c].lut_index = state.ch[c].lut_index + 8'h01; // RULE16
               if (state.ch[c].lut_loading && state.ch[c].lut_index == LUT_LAST) begin
                  next_state.ch[c].lut_done = 1'b1; // RULE14
                  next_state.ch[c].lut_loading = 1'b0;
               end
            end
            if (is_chan(req.addr, SUB_THRESH, c)) begin
               if (req.wr_data[7:0] != 8'h00) begin // RULE17
                  next_state.ch[c].thresh = req.wr_data[7:0];
               end
               next_state.ch[c].thresh_bypass = apply_code(state.ch[c].thresh_bypass, code, 2'h0); // RULE18
               next_state.ch[c].thresh_code = code;
            end
         end
      end
      // read path, registered so data comes from a flip-flop
      next_state.rd = 32'h00000000; // RULE21
      case (req.addr)
         OFS_SCRATCH: next_state.rd = state.scratch;
         OFS_TRAFFIC: next_state.rd = {31'h00000000, state.traffic};
         OFS_UOUT_CTRL: next_state.rd = {16'h0000, state.uout_ctrl};
         OFS_UOUT_STATE: next_state.rd = {24'h000000, io_status.uout}; // RULE5
         OFS_IO_ONE: next_state.rd = {22'h000000, io_status.io_one}; // RULE6
         OFS_IO_TWO: next_state.rd = {22'h000000, io_status.io_two}; // RULE7
         OFS_EXT_LOW: next_state.rd = io_status.ext_io[31:0]; // RULE8
         OFS_EXT_HIGH: next_state.rd = {24'h000000, io_status.ext_io[39:32]}; // RULE9
         default: begin
         end
      endcase
      for (int unsigned c = 0; c < NUM_CHAN; c++) begin
         if (is_chan(req.addr, SUB_LINE, c)) begin
            next_state.rd = {30'h00000000, state.ch[c].line_bypass ? CODE_ON : CODE_OFF};
         end
         if (is_chan(req.addr, SUB_EVENT, c)) begin
            next_state.rd = state.ch[c].event_arg;
         end
         if (is_chan(req.addr, SUB_LUT, c)) begin
            // start bit is write-only and always reads zero
            next_state.rd = {22'h000000, state.ch[c].lut_bypass ? CODE_ON : CODE_OFF, 3'h0, state.ch[c].lut_done, 4'h0};
         end
         if (is_chan(req.addr, SUB_THRESH, c)) begin
            next_state.rd = {22'h000000, state.ch[c].thresh_bypass ? CODE_ON : CODE_OFF, state.ch[c].thresh};
         end
      end
   end

   // ----------------------------------------
   // state register
   // ----------------------------------------
   always_ff @(posedge sys_clk) begin
      if (!rst_b) begin // RULE22
         state.scratch <= RST_SCRATCH;
         state.traffic <= 1'b0;
         state.uout_ctrl <= RST_UOUT_CTRL;
         state.rd <= 32'h00000000;
         for (int unsigned c = 0; c < NUM_CHAN; c++) begin
            state.ch[c].line_bypass <= 1'b1;
            state.ch[c].line_code <= 2'h0;
            state.ch[c].event_arg <= 32'h00000000;
            state.ch[c].event_pulse <= 1'b0;
            state.ch[c].lut_done <= 1'b0;
            state.ch[c].lut_loading <= 1'b0;
            state.ch[c].lut_bypass <= 1'b1;
            state.ch[c].lut_code <= 2'h0;
            state.ch[c].lut_index <= 8'h00;
            state.ch[c].lut_we <= 1'b0;
            state.ch[c].lut_addr <= 8'h00;
            state.ch[c].lut_data <= 8'h00;
            state.ch[c].thresh <= RST_THRESH;
            state.ch[c].thresh_bypass <= 1'b1;
            state.ch[c].thresh_code <= 2'h0;
         end
      end else begin
         state <= next_state;
      end
   end

   assign rd_data = state.rd;
   assign traffic_gen_enable = state.traffic;
   assign user_output_control = state.uout_ctrl; // RULE20
   assign chan = state.ch;
endmodule
`default_nettype wire

/* design/rcrm_pkg.sv */
// package: register map, field layouts and reset values of the control register bank
// Notes on behaviour
// (RULE1) word zero is scratch, cleared at reset
// (RULE2) traffic generator enable bit, off at reset
// (RULE3) eight two-bit user output control fields
// (RULE4) 01 drives high, 10 low, else hold
// (RULE5) user output states read back bits 7:0
// (RULE6) first standard io set status, ten bits
// (RULE7) second standard io set status, ten bits
// (RULE8) extension io 1 to 32 readback
// (RULE9) extension io 33 to 40 readback
// (RULE10) channel registers at 0x1n0x, n selects channel
// (RULE11) per channel line extract bypass, on at reset
// (RULE12) event register write stores value, pulses event
// (RULE13) lut bit 0 starts load, self clearing
// (RULE14) lut bit 4 shows load complete
// (RULE15) lut bypass bits 9:8, 01 on, 10 off
// (RULE16) coefficient write stores entry, advances index
// (RULE17) nonzero threshold write sets level, reset one
// (RULE18) threshold bypass bits 9:8, 01 on, 10 off
// (RULE19) host strobes write for one cycle each
// (RULE20) control field acts once per detected change; the bank passes prev as 00, so every 01 or 10 bypass code write acts
// (RULE21) read data shows addressed register, else zero
// (RULE22) all state on one clock, synchronous reset
package rcrm_pkg;
   localparam int unsigned NUM_CHAN = 4;
   localparam int unsigned NUM_UOUT = 8;
   localparam int unsigned LUT_DEPTH = 256;
   localparam logic [15:0] OFS_SCRATCH = 16'h0000;
   localparam logic [15:0] OFS_TRAFFIC = 16'h0001;
   localparam logic [15:0] OFS_UOUT_CTRL = 16'h0002;
   localparam logic [15:0] OFS_UOUT_STATE = 16'h0003;
   localparam logic [15:0] OFS_IO_ONE = 16'h0004;
   localparam logic [15:0] OFS_IO_TWO = 16'h0005;
   localparam logic [15:0] OFS_EXT_LOW = 16'h0006;
   localparam logic [15:0] OFS_EXT_HIGH = 16'h0007;
   localparam logic [3:0] CHAN_PREFIX = 4'h1;
   localparam logic [3:0] CHAN_MID = 4'h0;
   localparam logic [3:0] SUB_LINE = 4'h0;
   localparam logic [3:0] SUB_EVENT = 4'h1;
   localparam logic [3:0] SUB_LUT = 4'h2;
   localparam logic [3:0] SUB_COEF = 4'h3;
   localparam logic [3:0] SUB_THRESH = 4'h4;
   localparam int unsigned LUT_START_BIT = 0;
   localparam int unsigned LUT_DONE_BIT = 4;
   localparam int unsigned BYP_LSB = 8;
   localparam logic [1:0] CODE_ON = 2'h1;
   localparam logic [1:0] CODE_OFF = 2'h2;
   localparam logic [31:0] RST_SCRATCH = 32'h00000000;
   localparam logic [7:0] RST_THRESH = 8'h01;
   localparam logic [7:0] LUT_LAST = 8'hFF;
   localparam logic [15:0] RST_UOUT_CTRL = 16'h0000;

   typedef struct packed {
      logic [15:0] addr;
      logic wr_en;
      logic [31:0] wr_data;
   } rcrm_req_t;

   typedef struct packed {
      logic [9:0] io_one;
      logic [9:0] io_two;
      logic [39:0] ext_io;
      logic [7:0] uout;
   } rcrm_io_t;

   typedef struct packed {
      logic line_bypass;
      logic [1:0] line_code;
      logic [31:0] event_arg;
      logic event_pulse;
      logic lut_done;
      logic lut_loading;
      logic lut_bypass;
      logic [1:0] lut_code;
      logic [7:0] lut_index;
      logic lut_we;
      logic [7:0] lut_addr;
      logic [7:0] lut_data;
      logic [7:0] thresh;
      logic thresh_bypass;
      logic [1:0] thresh_code;
   } rcrm_chan_t;
endpackage

/* verif/rcrm_bank_asserts.sv */
// concurrent checks on the control register bank ports
`timescale 1ns/1ps
`default_nettype none
module rcrm_bank_asserts (
   input wire logic sys_clk,
   input wire logic rst_b,
   input wire rcrm_pkg::rcrm_req_t req,
   input wire rcrm_pkg::rcrm_io_t io_status,
   input wire logic [31:0] rd_data,
   input wire logic traffic_gen_enable,
   input wire logic [15:0] user_output_control,
   input wire rcrm_pkg::rcrm_chan_t [rcrm_pkg::NUM_CHAN-1:0] chan
);
   import rcrm_pkg::*;
   default clocking cb @(posedge sys_clk); endclocking
   default disable iff (!rst_b);
   // ----------------------------------------
   // write and read sequences
   // ----------------------------------------
   sequence wr_to(logic [15:0] a);
      req.wr_en && req.addr == a;
   endsequence
   sequence held_rd(logic [15:0] a);
      req.addr == a && !req.wr_en;
   endsequence
   AST_RESET: assert property (disable iff (1'b0) !rst_b |=> rd_data == 32'h0 && chan[0].thresh == RST_THRESH)
      else $error("reset values wrong");
   AST_SCRATCH: assert property (wr_to(OFS_SCRATCH) ##1 held_rd(OFS_SCRATCH) |=> rd_data == $past(req.wr_data, 2))
      else $error("scratch readback wrong");
   AST_TRAFFIC: assert property (wr_to(OFS_TRAFFIC) |=> traffic_gen_enable == $past(req.wr_data[0]))
      else $error("traffic enable not stored");
   AST_LSTART: assert property (wr_to(16'h1002) ##0 req.wr_data[0] |=> !chan[0].lut_done && chan[0].lut_loading && chan[0].lut_index == 8'h00)
      else $error("table load did not restart");
   AST_UCTRL: assert property (wr_to(OFS_UOUT_CTRL) |=> user_output_control == $past(req.wr_data[15:0]))
      else $error("control word not stored");
   AST_USTATE: assert property (req.addr == OFS_UOUT_STATE |=> rd_data == {24'h0, $past(io_status.uout)})
      else $error("output state readback wrong");
   AST_UNMAP: assert property (req.addr == 16'h0008 || req.addr == 16'h1400 |=> rd_data == 32'h0)
      else $error("unmapped read not zero");
   AST_EVENT: assert property (wr_to(16'h1101) |=> chan[1].event_pulse && chan[1].event_arg == $past(req.wr_data))
      else $error("event not raised");
   AST_EVONE: assert property (chan[1].event_pulse |-> $past(req.wr_en && req.addr == 16'h1101))
      else $error("event without write");
   AST_THR0: assert property (wr_to(16'h1104) ##0 req.wr_data[7:0] == 8'h00 |=> $stable(chan[1].thresh))
      else $error("zero threshold changed level");
   AST_COEF: assert property (wr_to(16'h1003) |=> chan[0].lut_we && chan[0].lut_data == $past(req.wr_data[7:0]))
      else $error("coefficient not written");
endmodule
bind rcrm_bank rcrm_bank_asserts chk_i (.sys_clk, .rst_b, .req, .io_status, .rd_data, .traffic_gen_enable,
   .user_output_control, .chan);
`default_nettype wire

/* verif/rcrm_bank_bench.sv */
// self-checking bench for the control register bank
`timescale 1ns/1ps
`default_nettype none
module rcrm_bank_bench;
   import rcrm_pkg::*;
   logic sys_clk = 1'b0;
   logic rst_b = 1'b0;
   rcrm_req_t req = '0;
   logic [9:0] io1 = 10'h000;
   logic [9:0] io2 = 10'h000;
   logic [39:0] ext = 40'h0000000000;
   logic [7:0] uout;
   logic [31:0] rd_data;
   logic tge;
   logic [15:0] uctrl;
   rcrm_io_t io_status;
   rcrm_chan_t [NUM_CHAN-1:0] chan;
   int bad_count = 0;
   int checks_done = 0;
   assign io_status = {io1, io2, ext, uout};
   always #4 sys_clk = ~sys_clk;
   rcrm_bank uut (.sys_clk, .rst_b, .req, .io_status, .rd_data, .traffic_gen_enable(tge),
      .user_output_control(uctrl), .chan);
   rcrm_uout_model fw (.sys_clk, .rst_b, .ctrl(uctrl), .uout);
   // ----------------------------------------
   // bus cycles and compare
   // ----------------------------------------
   task automatic chk(input logic [31:0] g, input logic [31:0] e);
      checks_done++;
      if (g !== e) begin
         bad_count++;
         $display("Error at %0t: got %h expected %h", $time, g, e);
      end
   endtask
   task automatic wr(input logic [15:0] a, input logic [31:0] d);
      @(posedge sys_clk);
      req <= '{a, 1'b1, d};
      @(posedge sys_clk);
      req.wr_en <= 1'b0;
      #1;
   endtask
   task automatic rd(input logic [15:0] a, input logic [31:0] e);
      @(posedge sys_clk);
      req <= '{a, 1'b0, 32'h0};
      @(posedge sys_clk);
      #1;
      chk(rd_data, e);
   endtask
   task automatic results();
      $display("checks %0d mismatches %0d", checks_done, bad_count);
      if (bad_count == 0 && checks_done > 0) begin
         $display("All checks passed");
      end else begin
         $display("Checks failed");
      end
      $finish;
   endtask
   // ----------------------------------------
   // scenarios
   // ----------------------------------------
   task automatic t_reset();
      rd(OFS_SCRATCH, RST_SCRATCH);
      rd(OFS_TRAFFIC, 32'h0);
      rd(16'h1000, 32'h1);
      rd(16'h1002, 32'h100);
      rd(16'h1304, 32'h101);
      $display("reset values done");
   endtask
   task automatic t_global();
      wr(OFS_SCRATCH, 32'hA5A50FF0);
      wr(OFS_TRAFFIC, 32'hFFFFFFFE);
      rd(OFS_SCRATCH, 32'hA5A50FF0);
      rd(OFS_TRAFFIC, 32'h0);
      wr(OFS_TRAFFIC, 32'h1);
      chk({31'h0, tge}, 32'h1);
      wr(OFS_IO_ONE, 32'hFFFFFFFF);
      rd(OFS_IO_ONE, 32'h0);
      rd(16'h0008, 32'h0);
      $display("global registers done");
   endtask
   task automatic t_uout();
      wr(OFS_UOUT_CTRL, 32'h5555);
      rd(OFS_UOUT_STATE, 32'hFF);
      wr(OFS_UOUT_CTRL, 32'h5556);
      rd(OFS_UOUT_STATE, 32'hFE);
      wr(OFS_UOUT_CTRL, 32'hFFFF555B);
      rd(OFS_UOUT_STATE, 32'hFC);
      rd(OFS_UOUT_CTRL, 32'h555B);
      $display("user outputs done");
   endtask
   task automatic t_io();
      @(posedge sys_clk);
      io1 <= 10'h2A5;
      io2 <= 10'h15A;
      ext <= 40'hC312345678;
      rd(OFS_IO_ONE, 32'h2A5);
      rd(OFS_IO_TWO, 32'h15A);
      rd(OFS_EXT_LOW, 32'h12345678);
      rd(OFS_EXT_HIGH, 32'hC3);
      $display("io status done");
   endtask
   task automatic t_chan();
      wr(16'h1101, 32'hDEADBEEF);
      chk({31'h0, chan[1].event_pulse}, 32'h1);
      chk(chan[1].event_arg, 32'hDEADBEEF);
      @(posedge sys_clk);
      #1;
      chk({31'h0, chan[1].event_pulse}, 32'h0);
      wr(16'h1104, 32'h300);
      rd(16'h1104, 32'h101);
      wr(16'h1104, 32'h280);
      rd(16'h1104, 32'h280);
      wr(16'h1100, 32'h2);
      rd(16'h1100, 32'h2);
      rd(16'h1000, 32'h1);
      rd(16'h1400, 32'h0);
      $display("channel registers done");
   endtask
   task automatic t_lut();
      wr(16'h1002, 32'h1);
      rd(16'h1002, 32'h100);
      for (int i = 0; i < 256; i++) begin
         wr(16'h1003, 32'hFFFFFF00 | (i ^ 8'h5A));
         chk({15'h0, chan[0].lut_we, chan[0].lut_data, chan[0].lut_addr}, {15'h0, 1'b1, 8'(i ^ 8'h5A), 8'(i)});
      end
      rd(16'h1002, 32'h110);
      wr(16'h1002, 32'h200);
      wr(16'h1002, 32'h300);
      rd(16'h1002, 32'h210);
      wr(16'h1003, 32'h11);
      wr(16'h1003, 32'h22);
      wr(16'h1002, 32'h1);
      rd(16'h1002, 32'h200);
      wr(16'h1003, 32'h33);
      chk({15'h0, chan[0].lut_we, chan[0].lut_data, chan[0].lut_addr}, {15'h0, 1'b1, 8'h33, 8'h00});
      $display("lookup table done");
   endtask
   task automatic t_rerun();
      @(posedge sys_clk);
      rst_b <= 1'b0;
      repeat (2) @(posedge sys_clk);
      rst_b <= 1'b1;
      rd(OFS_SCRATCH, 32'h0);
      rd(16'h1104, 32'h101);
      rd(OFS_TRAFFIC, 32'h0);
      rd(OFS_UOUT_CTRL, 32'h0);
      rd(16'h1100, 32'h1);
      $display("second reset done");
   endtask
   // a hang past this bound is reported as a mismatch
   initial begin
      #40000;
      bad_count++;
      results();
   end
   initial begin
      repeat (3) @(posedge sys_clk);
      rst_b <= 1'b1;
      t_reset();
      t_global();
      t_uout();
      t_io();
      t_chan();
      t_lut();
      t_rerun();
      results();
   end
endmodule
`default_nettype wire

/* verif/rcrm_uout_model.sv */
// framework side model: user output lines driven from the control word
`timescale 1ns/1ps
`default_nettype none
module rcrm_uout_model (
   input wire logic sys_clk,
   input wire logic rst_b,
   input wire logic [15:0] ctrl,
   output var logic [7:0] uout
);
   logic [15:0] last = 16'h0000;
   initial uout = 8'h00;
   // a held code must not pin the line, so only changed fields act
   always @(posedge sys_clk) begin
      last <= ctrl;
      for (int k = 0; k < 8; k++) begin
         if (ctrl[2*k+:2] != last[2*k+:2] && ctrl[2*k+:2] == 2'h1) uout[k] <= 1'b1;
         if (ctrl[2*k+:2] != last[2*k+:2] && ctrl[2*k+:2] == 2'h2) uout[k] <= 1'b0;
      end
      if (!rst_b) begin
         last <= 16'h0000;
         uout <= 8'h00;
      end
   end
endmodule
`default_nettype wire
